// file: rtl/fixed_reference_defs.svh
`ifndef FIXED_REFERENCE_DEFS_SVH
`define FIXED_REFERENCE_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_CONTROL          12'h000
`define ADDR_STATUS           12'h004
`define ADDR_IRQ_STATUS       12'h008
`define ADDR_IRQ_MASK         12'h00C
`define ADDR_SYSTEM           12'h010

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_ENABLE_BIT        7
`define CTL_READY_BIT         6
`define CTL_CDG_HI            3
`define CTL_CDG_LO            2
`define CTL_ADG_HI            1
`define CTL_ADG_LO            0
`define CTL_WRITE_MASK        32'h0000008F

// ----------------------------------------------------------------
// System condition register fields
// ----------------------------------------------------------------
`define SYS_OSC_HI            2
`define SYS_OSC_LO            0
`define SYS_FREQ_HI           6
`define SYS_FREQ_LO           3
`define SYS_BOR_HI            8
`define SYS_BOR_LO            7
`define SYS_BROWNOUT_FAST_START_BIT         9
`define SYS_REGPM_BIT         10
`define SYS_WRITE_MASK        32'h000007FF

// ----------------------------------------------------------------
// Status / interrupt fields
// ----------------------------------------------------------------
`define ST_ON_BIT             0
`define ST_READY_BIT          1
`define ST_FORCED_BIT         2
`define IRQ_READY_RISE        0
`define IRQ_READY_FALL        1
`define IRQ_WIDTH             2

// ----------------------------------------------------------------
// Decode codes and reset values
// ----------------------------------------------------------------
`define OSC_INTERNAL          3'h4
`define FREQ_LOW_PREFIX       3'h0
`define BOR_ALWAYS            2'h3
`define BOR_SLEEP_OFF         2'h2
`define BOR_SOFTWARE          2'h1
`define CONTROL_RESET         8'h00
`define SYSTEM_RESET          11'h000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS         10
`define SETTLE_TIME_NS        30000
`define SETTLE_CYCLES         ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: rtl/fixed_reference_pkg.sv
package fixed_reference_pkg;

    typedef enum logic [1:0] {
        GAIN_OFF = 2'h0,
        GAIN_X1  = 2'h1,
        GAIN_X2  = 2'h2,
        GAIN_X4  = 2'h3
    } gain_e;

    typedef enum logic [1:0] {
        REF_OFF      = 2'h0,
        REF_SETTLING = 2'h1,
        REF_READY    = 2'h3
    } ref_state_e;

    typedef logic [2:0] gain_onehot_t;

endpackage

// file: rtl/settle_timer.sv
`timescale 1ns/1ps
`include "fixed_reference_defs.svh"

module settle_timer
    import fixed_reference_pkg::*;
#(
    parameter int CYCLES = `SETTLE_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    input  wire logic run,
    output logic      done
);

    localparam int CW = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 1) begin
            $error("settle_timer: CYCLES must be at least 1");
        end
    end

    logic [CW-1:0] count_r;

    // Restart reloads the full wait, so a gain change never shortens it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
        end else if (restart || !run) begin
            count_r <= CW'(CYCLES);
        end else if (count_r != '0) begin
            count_r <= count_r - CW'(1);
        end
    end

    assign done = run && !restart && (count_r == '0);

endmodule // settle_timer

// file: rtl/fixed_reference_control.sv
// Behaviour
// - Reference runs when enable bit set; off when clear and nobody requests it.
// - Three output levels 1.024, 2.048, 4.096 V chosen by gain.
// - Two independent gain buffers, each gain one, two or four.
// - ADC buffer gain field enables and sets the ADC buffer.
// - Comparator/DAC gain field enables and sets that buffer.
// - Ready flag rises only after reference and buffers have settled.
// - Internal oscillator code with frequency not 000x, awake, forces reference on.
// - Brown-out field 11, or 10/01 with fast start, forces reference on.
// - High-voltage variant: regulator mode 1 and awake forces reference on.
// - In sleep the regulator request is dropped.
// - Ready reads 0 when not ready or reference off (enable clear, nothing forcing it), 1 when usable; low-voltage variant only.
// - Gain code 00 off, 01 x1, 10 x2, 11 x4.
// - High-voltage variant reads ready constantly as 1.
`timescale 1ns/1ps
`include "fixed_reference_defs.svh"

module fixed_reference_control
    import fixed_reference_pkg::*;
#(
    parameter bit HIGH_VOLTAGE  = 1'b0,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_mode,
    output logic             reference_on,
    output logic      [2:0]  adc_buffer_sel,
    output logic      [2:0]  cmp_dac_buffer_sel,
    output logic             reference_ready_flag,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // A zero wait would let ready rise in the same cycle as the enable
    initial begin
        if (SETTLE_CYCLES < 1) begin
            $error("fixed_reference_control: SETTLE_CYCLES must be at least 1");
        end
    end

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    // One-hot select drives the analog gain switches directly
    function automatic gain_onehot_t decode_gain(input logic [1:0] code);
        gain_onehot_t sel;
        sel = 3'h0;
        unique case (gain_e'(code))
            GAIN_OFF: sel = 3'h0;
            GAIN_X1:  sel = 3'h1;
            GAIN_X2:  sel = 3'h2;
            GAIN_X4:  sel = 3'h4;
        endcase
        return sel;
    endfunction

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        return a == target;
    endfunction

    // ----------------------------------------------------------------
    // Bus access
    // ----------------------------------------------------------------
    logic access;
    logic take;
    logic wr_en;
    logic rd_en;
    logic mapped;

    // Only the first access cycle acts: a W1C clear repeated in the
    // answer cycle could otherwise wipe an event set one cycle earlier
    assign access = psel && penable;
    assign take   = access && !pready;
    assign wr_en  = take && pwrite && pstrb[0];
    assign rd_en  = take && !pwrite;
    assign mapped = addr_hit(paddr, `ADDR_CONTROL) || addr_hit(paddr, `ADDR_STATUS)
                 || addr_hit(paddr, `ADDR_IRQ_STATUS) || addr_hit(paddr, `ADDR_IRQ_MASK)
                 || addr_hit(paddr, `ADDR_SYSTEM);

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Control holds enable and both gain fields; system mirrors the device
    // configuration (oscillator, frequency, brown-out, regulator mode)
    logic [7:0]           control_r;
    logic [10:0]          system_r;
    logic [`IRQ_WIDTH-1:0] irq_mask_r;
    logic [`IRQ_WIDTH-1:0] irq_status_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_r <= `CONTROL_RESET;
        end else if (wr_en && addr_hit(paddr, `ADDR_CONTROL)) begin
            control_r <= pwdata[7:0] & 8'(`CTL_WRITE_MASK);
        end
    end

    // Byte lanes 0 and 1 both carry system condition bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_r <= `SYSTEM_RESET;
        end else if (take && pwrite && addr_hit(paddr, `ADDR_SYSTEM)) begin
            if (pstrb[0]) begin
                system_r[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                system_r[10:8] <= pwdata[10:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= '0;
        end else if (wr_en && addr_hit(paddr, `ADDR_IRQ_MASK)) begin
            irq_mask_r <= pwdata[`IRQ_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Peripheral requests
    // ----------------------------------------------------------------
    logic       enable_bit;
    logic [2:0] osc_sel;
    logic [3:0] freq_sel;
    logic [1:0] bor_field;
    logic       bor_fast;
    logic       reg_mode;
    logic       osc_request;
    logic       bor_request;
    logic       ldo_request;
    logic       forced;
    logic       ref_nxt;

    assign enable_bit = control_r[`CTL_ENABLE_BIT];
    assign osc_sel    = system_r[`SYS_OSC_HI:`SYS_OSC_LO];
    assign freq_sel   = system_r[`SYS_FREQ_HI:`SYS_FREQ_LO];
    assign bor_field  = system_r[`SYS_BOR_HI:`SYS_BOR_LO];
    assign bor_fast   = system_r[`SYS_BROWNOUT_FAST_START_BIT];
    assign reg_mode   = system_r[`SYS_REGPM_BIT];

    assign osc_request = (osc_sel == `OSC_INTERNAL)
                      && (freq_sel[3:1] != `FREQ_LOW_PREFIX) && !sleep_mode;
    assign bor_request = (bor_field == `BOR_ALWAYS)
                      || ((bor_field == `BOR_SLEEP_OFF) && bor_fast)
                      || ((bor_field == `BOR_SOFTWARE) && bor_fast);
    // Sleep hands the core to the low-power regulator, so no request then
    assign ldo_request = HIGH_VOLTAGE && reg_mode && !sleep_mode;
    // Forced is visible in status, so software can tell who holds it on
    assign forced      = osc_request || bor_request || ldo_request;
    assign ref_nxt     = enable_bit || forced;

    // ----------------------------------------------------------------
    // Analog controls and settling
    // ----------------------------------------------------------------
    gain_onehot_t adc_nxt;
    gain_onehot_t cd_nxt;
    logic         gain_change;
    logic         settled;
    ref_state_e   state_r;
    logic         ready_nxt;

    assign adc_nxt = decode_gain(control_r[`CTL_ADG_HI:`CTL_ADG_LO]);
    assign cd_nxt  = decode_gain(control_r[`CTL_CDG_HI:`CTL_CDG_LO]);
    assign gain_change = (adc_nxt != adc_buffer_sel) || (cd_nxt != cmp_dac_buffer_sel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_on       <= 1'b0;
            adc_buffer_sel     <= 3'h0;
            cmp_dac_buffer_sel <= 3'h0;
        end else begin
            reference_on       <= ref_nxt;
            adc_buffer_sel     <= adc_nxt;
            cmp_dac_buffer_sel <= cd_nxt;
        end
    end

    // Any buffer change reopens the settling wait
    // Settling is counted in pclk cycles; rescale SETTLE_CYCLES with the clock
    settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (gain_change || (ref_nxt && !reference_on)),
        .run     (ref_nxt),
        .done    (settled)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= REF_OFF;
        end else begin
            unique case (state_r)
                REF_OFF:      state_r <= ref_nxt ? REF_SETTLING : REF_OFF;
                REF_SETTLING: state_r <= !ref_nxt ? REF_OFF
                                       : (settled ? REF_READY : REF_SETTLING);
                REF_READY:    state_r <= !ref_nxt ? REF_OFF
                                       : (gain_change ? REF_SETTLING : REF_READY);
                default:      state_r <= REF_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Ready flag
    // ----------------------------------------------------------------
    // A gain change drops ready at once rather than waiting for the timer
    assign ready_nxt = HIGH_VOLTAGE ? 1'b1
                     : (ref_nxt && !gain_change
                        && (state_r == REF_READY
                            || (state_r == REF_SETTLING && settled)));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // High-voltage variant reads ready from reset onwards
            reference_ready_flag <= HIGH_VOLTAGE;
        end else begin
            reference_ready_flag <= ready_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [`IRQ_WIDTH-1:0] irq_event;
    logic [`IRQ_WIDTH-1:0] irq_clear;
    logic [`IRQ_WIDTH-1:0] irq_status_nxt;

    assign irq_event[`IRQ_READY_RISE] = ready_nxt && !reference_ready_flag;
    assign irq_event[`IRQ_READY_FALL] = !ready_nxt && reference_ready_flag;
    assign irq_clear = (wr_en && addr_hit(paddr, `ADDR_IRQ_STATUS))
                     ? pwdata[`IRQ_WIDTH-1:0] : '0;
    // Set wins over a clear in the same cycle
    assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    // A set mask bit lets its status bit raise irq; irq uses the new
    // status so it never lags the flag by a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_nxt & irq_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // Read data and response
    // ----------------------------------------------------------------
    logic [31:0] rdata_nxt;

    // Unused bits and unmapped offsets read as zero
    always_comb begin
        rdata_nxt = 32'h0;
        if (addr_hit(paddr, `ADDR_CONTROL)) begin
            rdata_nxt[7:0] = control_r;
            rdata_nxt[`CTL_READY_BIT] = reference_ready_flag;
        end else if (addr_hit(paddr, `ADDR_STATUS)) begin
            rdata_nxt[`ST_ON_BIT]     = reference_on;
            rdata_nxt[`ST_READY_BIT]  = reference_ready_flag;
            rdata_nxt[`ST_FORCED_BIT] = forced;
        end else if (addr_hit(paddr, `ADDR_IRQ_STATUS)) begin
            rdata_nxt[`IRQ_WIDTH-1:0] = irq_status_r;
        end else if (addr_hit(paddr, `ADDR_IRQ_MASK)) begin
            rdata_nxt[`IRQ_WIDTH-1:0] = irq_mask_r;
        end else if (addr_hit(paddr, `ADDR_SYSTEM)) begin
            rdata_nxt[10:0] = system_r;
        end
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= take;
            pslverr <= take && !mapped;
            prdata  <= rd_en ? rdata_nxt : 32'h0;
        end
    end

endmodule // fixed_reference_control

// file: testbench/fixed_reference_sva.sv
`timescale 1ns/1ps
`include "fixed_reference_defs.svh"

module fixed_reference_sva #(
    parameter bit HIGH_VOLTAGE  = 1'b0,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        sleep_mode,
    input wire logic        reference_on,
    input wire logic [2:0]  adc_buffer_sel,
    input wire logic [2:0]  cmp_dac_buffer_sel,
    input wire logic        reference_ready_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // Shadow of the software-visible settings
    // ----------------------------------------------------------------
    logic [7:0]  ctl_r;
    logic [10:0] sys_r;
    int          wait_cnt;
    wire acc    = psel && penable && pwrite && !pready;
    wire wr_ctl = acc && paddr == `ADDR_CONTROL && pstrb[0];
    wire wr_sys = acc && paddr == `ADDR_SYSTEM;
    wire osc_c  = sys_r[2:0] == 3'h4 && sys_r[6:4] != 3'h0 && !sleep_mode;
    wire bor_c  = sys_r[8:7] == 2'h3 || (sys_r[8:7] != 2'h0 && sys_r[9]);
    wire ldo_c  = HIGH_VOLTAGE && sys_r[10] && !sleep_mode;
    wire req_c  = ctl_r[7] || osc_c || bor_c || ldo_c;

    function automatic logic [2:0] dec(input logic [1:0] g);
        return (g == 2'h0) ? 3'h0 : 3'h1 << (g - 2'h1);
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 8'h00;
            sys_r <= 11'h000;
        end else begin
            if (wr_ctl) ctl_r <= pwdata[7:0] & 8'h8F;
            if (wr_sys && pstrb[0]) sys_r[7:0] <= pwdata[7:0];
            if (wr_sys && pstrb[1]) sys_r[10:8] <= pwdata[10:8];
        end
    end

    // A gain write restarts settling, so it restarts the wait as well
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wait_cnt <= 0;
        else if (!reference_on || reference_ready_flag || wr_ctl) wait_cnt <= 0;
        else wait_cnt <= wait_cnt + 1;
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_on_follows; req_c && $past(req_c) |-> reference_on; endproperty
    a_on_follows: assert property (p_on_follows) else $error("reference not on");
    property p_off_follows; !req_c && !$past(req_c) |-> !reference_on; endproperty
    a_off_follows: assert property (p_off_follows) else $error("reference not off");
    property p_osc; osc_c && $past(osc_c) |-> reference_on; endproperty
    a_osc: assert property (p_osc) else $error("oscillator request ignored");
    property p_bor; bor_c [*2] |-> reference_on; endproperty
    a_bor: assert property (p_bor) else $error("brown-out request ignored");
    property p_ldo; $rose(ldo_c) ##1 ldo_c |-> reference_on; endproperty
    a_ldo: assert property (p_ldo) else $error("regulator request ignored");
    property p_adc_gain; $stable(ctl_r) |-> adc_buffer_sel == dec(ctl_r[1:0]); endproperty
    a_adc_gain: assert property (p_adc_gain) else $error("adc buffer decode wrong");
    property p_cmp_gain; $stable(ctl_r) |-> cmp_dac_buffer_sel == dec(ctl_r[3:2]); endproperty
    a_cmp_gain: assert property (p_cmp_gain) else $error("cmp buffer decode wrong");
    property p_ready_off; !HIGH_VOLTAGE && !reference_on [*2] |-> !reference_ready_flag;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while off");
    property p_ready_early; !HIGH_VOLTAGE && $rose(reference_on) |-> !reference_ready_flag [*4];
    endproperty
    a_ready_early: assert property (p_ready_early) else $error("ready too early");
    property p_ready_late; wait_cnt <= SETTLE_CYCLES + 6; endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready too late");
    property p_hv_ready; HIGH_VOLTAGE |-> reference_ready_flag; endproperty
    a_hv_ready: assert property (p_hv_ready) else $error("ready not held high");
endmodule // fixed_reference_sva

bind fixed_reference_control fixed_reference_sva #(
    .HIGH_VOLTAGE(HIGH_VOLTAGE), .SETTLE_CYCLES(SETTLE_CYCLES)
) i_fixed_reference_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .sleep_mode(sleep_mode),
    .reference_on(reference_on), .adc_buffer_sel(adc_buffer_sel),
    .cmp_dac_buffer_sel(cmp_dac_buffer_sel), .reference_ready_flag(reference_ready_flag)
);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "fixed_reference_defs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, a, e); end end

module tb_top;
    import fixed_reference_pkg::*;
    localparam int SC = 5;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, sleep_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, reference_on, ready, irq, hv_on, hv_ready, er;
    logic [2:0]  adc_sel, cmp_sel;
    int          err_count = 0, checked = 0;
    // Bits: 13 high-voltage on, 12 low-voltage on, 11 sleep, 10:0 system word
    logic [13:0] tbl [11] = '{14'h3014, 14'h0814, 14'h000C, 14'h0013, 14'h3980, 14'h3300,
                              14'h0100, 14'h3280, 14'h0080, 14'h2400, 14'h0C00};

    fixed_reference_control #(.SETTLE_CYCLES(SC)) i_fixed_reference_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(sleep_mode), .reference_on(reference_on),
        .adc_buffer_sel(adc_sel), .cmp_dac_buffer_sel(cmp_sel),
        .reference_ready_flag(ready), .irq(irq));

    // Second variant shares the bus; only its reference outputs are watched
    fixed_reference_control #(.HIGH_VOLTAGE(1'b1), .SETTLE_CYCLES(SC))
        i_fixed_reference_control_hv (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
        .sleep_mode(sleep_mode), .reference_on(hv_on), .adc_buffer_sel(),
        .cmp_dac_buffer_sel(), .reference_ready_flag(hv_ready), .irq());

    always #5 pclk = ~pclk;

    function automatic logic [2:0] dec(input logic [1:0] g);
        return (g == 2'h0) ? 3'h0 : 3'h1 << (g - 2'h1);
    endfunction

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        `CHK(n, 2)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic wr_wait(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge pclk);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < SC + 20) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic tally_and_finish;
        $display("Comparisons: %0d  mismatches: %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(hv_ready, 1'b1)
        `CHK({reference_on, ready}, 2'h0)
        rdchk(`ADDR_CONTROL, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, `ADDR_CONTROL, 32'(32'h80 | (g << 2) | (3 - g)));
            `CHK(ready, 1'b0)
            wait_ready;
            `CHK(adc_sel, dec(2'(3 - g)))
            `CHK(cmp_sel, dec(2'(g)))
            `CHK({reference_on, ready}, 2'h3)
            rdchk(`ADDR_CONTROL, 32'(32'hC0 | (g << 2) | (3 - g)));
            rdchk(`ADDR_STATUS, 32'h3);
        end
        rdchk(`ADDR_IRQ_STATUS, 32'h3);
        wr_wait(`ADDR_IRQ_MASK, 32'h0);
        `CHK(irq, 1'b0)
        wr_wait(`ADDR_IRQ_MASK, 32'h1);
        `CHK(irq, 1'b1)
        wr_wait(`ADDR_IRQ_STATUS, 32'h1);
        `CHK(irq, 1'b0)
        rdchk(`ADDR_IRQ_STATUS, 32'h2);
        wr_wait(`ADDR_IRQ_MASK, 32'h3);
        `CHK(irq, 1'b1)
        wr_wait(`ADDR_IRQ_STATUS, 32'h2);
        `CHK(irq, 1'b0)
        wr_wait(`ADDR_CONTROL, 32'h0);
        `CHK({reference_on, ready, irq}, 3'h1)
        rdchk(`ADDR_IRQ_STATUS, 32'h2);
        wr_wait(`ADDR_IRQ_STATUS, 32'h2);
        foreach (tbl[i]) begin
            sleep_mode <= tbl[i][11];
            wr_wait(`ADDR_SYSTEM, {21'h0, tbl[i][10:0]});
            `CHK(reference_on, tbl[i][12])
            `CHK(hv_on, tbl[i][13])
        end
        tally_and_finish;
    end
endmodule // tb_top
